// >>> shared/bcc_pkg.sv
// Constants, field layouts and carrier types of the boost converter control.
// Assumes one 20 MHz clock and a classic Wishbone slave with 32-bit data.
// Overview of operation
// - Sample cell-mode strap at power-on reset
// - Dual-cell mode keeps converter always off
// - Single-cell: off in Sleep, else on
// - Cell mode changes only at power-on reset
// - Too-short on-time skips the whole pulse
// - Skipping turns switching into pulse-frequency modulation
// - Control bit 5 picks large or small switches
// - Config bit 0 picks oscillator or system clock
// - Own oscillator runs near 2.4 MHz
// - Two-bit field at bits 6:5 divides system clock path
// - Config bit 3 inverts system clock path
// - Min pulse codes: none, 20, 40, 80 ns
// - Switch select: 0 large, 1 small
// - Fixed 50% duty at power-on until regulating
package bcc_pkg;

	// Clock rate of the block
	localparam int CLK_PERIOD_NS = 50;
	localparam int CLK_FREQ_KHZ  = 20000;

	// Own oscillator rate and its period in clock cycles (rounded down)
	localparam int        OSC_FREQ_KHZ   = 2400;
	localparam logic [7:0] OSC_PERIOD_CYC =
		8'(CLK_FREQ_KHZ / OSC_FREQ_KHZ);

	// Undivided system clock path period in clock cycles
	localparam logic [7:0] SYS_BASE_CYC = 8'h02;

	// Minimum pulse widths, least times rounded up to whole cycles
	localparam int PW_MIN_1_NS = 20;
	localparam int PW_MIN_2_NS = 40;
	localparam int PW_MIN_3_NS = 80;
	localparam logic [7:0] PW_MIN_1_CYC =
		8'((PW_MIN_1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] PW_MIN_2_CYC =
		8'((PW_MIN_2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] PW_MIN_3_CYC =
		8'((PW_MIN_3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// Control register field positions
	localparam int CTRL_PW_MIN_LSB = 6;
	localparam int CTRL_SWSIZE     = 5;
	localparam int CTRL_SYNC       = 3;

	// Configuration register field positions
	localparam int CFG_SRC     = 0;
	localparam int CFG_INV     = 3;
	localparam int CFG_DIV_LSB = 5;

	// Status register bit positions
	localparam int STAT_SINGLE  = 0;
	localparam int STAT_ENABLED = 1;
	localparam int STAT_STARTUP = 2;
	localparam int STAT_SKIP    = 3;

	// Values after reset
	localparam logic [7:0] CTRL_RESET = 8'h20;
	localparam logic [7:0] CFG_RESET  = 8'h00;

	// Clock source codes
	localparam logic SRC_OSC = 1'b0;
	localparam logic SRC_SYS = 1'b1;

	// Control register contents
	typedef struct packed {
		logic [1:0] min_pw;
		logic       small_sw;
		logic       sync;
	} bcc_ctrl_t;

	// Clock path configuration
	typedef struct packed {
		logic [1:0] div;
		logic       inv;
		logic       src;
	} bcc_cfg_t;

endpackage

// >>> hw/bcc_sw_timer.sv
// Switching period timer: a phase counter over one switching period.
// Assumes the period input only changes in the cycle of period_start_o.
`timescale 1ns/1ps
module bcc_sw_timer
	import bcc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       run_i,
	input  wire logic [7:0] period_i,
	output logic [7:0]      phase_o,
	output logic            period_start_o
);

	logic [7:0] phase_q;    // Position within the current period
	logic       last_phase; // Final cycle of the period

	assign last_phase     = (phase_q >= period_i - 8'h01);
	assign phase_o        = phase_q;
	assign period_start_o = run_i & last_phase;

	// Count cycles, wrap at the period end, hold at zero while idle
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			phase_q <= 8'h00;
		end else if (last_phase) begin
			phase_q <= 8'h00;
		end else begin
			phase_q <= phase_q + 8'h01;
		end
	end

endmodule

// >>> hw/bcc_top.sv
// Boost converter digital control: cell mode latch, enable gating,
// switching clock selection, pulse skipping and switch size select.
// Assumes por_i is high during power-on reset and that the analog
// loop supplies the wanted on-time each period on duty_req_i.
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module bcc_top
	import bcc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        por_i,
	input  wire logic        cell_mode_strap_pin_i,
	input  wire logic        sleep_i,
	input  wire logic        reg_ok_i,
	input  wire logic [7:0]  duty_req_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             conv_enable_o,
	output logic             duty_switch_o,
	output logic             bypass_switch_o,
	output logic             small_switch_o,
	output logic             sw_clk_o,
	output logic             pulse_skip_o,
	output logic             adc_sync_o
);

	// Minimum on-time in cycles for a pulse width code
	function automatic logic [7:0] min_cycles(input logic [1:0] code);
		logic [7:0] r;
		r = 8'h00;
		case (code)
			2'b01:   r = PW_MIN_1_CYC;
			2'b10:   r = PW_MIN_2_CYC;
			2'b11:   r = PW_MIN_3_CYC;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// Switching period in cycles for a clock path setting
	function automatic logic [7:0] period_of(input bcc_cfg_t c);
		logic [7:0] r;
		r = OSC_PERIOD_CYC;
		if (c.src == SRC_SYS) begin
			r = SYS_BASE_CYC << c.div;
		end
		return r;
	endfunction

	// Software visible registers and the clock path copy in use
	bcc_ctrl_t  ctrl_q;        // Pulse width, switch size, sync
	bcc_cfg_t   cfg_q;         // Clock path as written
	bcc_cfg_t   cfg_act_q;     // Clock path in use this period

	// Converter state
	logic       single_cell_q; // Latched cell mode, 1 means one cell
	logic       enable_q;      // Converter running
	logic       startup_q;     // Fixed duty phase after power-on
	logic [7:0] on_act_q;      // On-time for the current period
	logic       skip_q;        // Current period was skipped

	// Bus handshake
	logic        wb_req;       // New access this cycle
	logic        wb_wr;        // New write this cycle
	logic [31:0] rd_data;      // Read mux result

	// Timer signals
	logic [7:0] phase;         // Position in the period
	logic       period_start;  // Last cycle of a period
	logic [7:0] period_act;    // Period length in use
	logic [7:0] period_new;    // Period length for the next period
	logic [7:0] want_on;       // On-time asked for the next period
	logic [7:0] min_on;        // Least legal on-time
	logic       do_skip;       // Next pulse is dropped

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

	assign period_act = period_of(cfg_act_q);
	assign period_new = period_of(cfg_q);
	assign min_on     = min_cycles(ctrl_q.min_pw);

	// The timer runs only while the converter is enabled
	bcc_sw_timer u_timer (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.run_i          (enable_q),
		.period_i       (period_act),
		.phase_o        (phase),
		.period_start_o (period_start)
	);

	// Cell mode latch. Only the power-on reset samples the strap, so
	// neither rst_i nor a later change of the pin can disturb it.
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			single_cell_q <= cell_mode_strap_pin_i;
		end
	end

	// Enable gating by cell mode and power mode
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			enable_q <= 1'b0;
		end else if (!single_cell_q) begin
			enable_q <= 1'b0;
		end else begin
			enable_q <= ~sleep_i;
		end
	end

	// Startup: fixed half duty from power-on until regulation holds.
	// A warm reset does not restart it, the output is already up.
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			startup_q <= 1'b1;
		end else if (reg_ok_i) begin
			startup_q <= 1'b0;
		end
	end

	// Control register write
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			ctrl_q <= '{min_pw: CTRL_RESET[CTRL_PW_MIN_LSB +: 2],
				small_sw: CTRL_RESET[CTRL_SWSIZE],
				sync: CTRL_RESET[CTRL_SYNC]};
		end else if (wb_wr && wb_adr_i == ADDR_CTRL) begin
			ctrl_q.min_pw   <= wb_dat_i[CTRL_PW_MIN_LSB +: 2];
			ctrl_q.small_sw <= wb_dat_i[CTRL_SWSIZE];
			ctrl_q.sync     <= wb_dat_i[CTRL_SYNC];
		end
	end

	// Configuration register write
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			cfg_q <= '{div: CFG_RESET[CFG_DIV_LSB +: 2],
				inv: CFG_RESET[CFG_INV], src: CFG_RESET[CFG_SRC]};
		end else if (wb_wr && wb_adr_i == ADDR_CONFIG) begin
			cfg_q.src <= wb_dat_i[CFG_SRC];
			cfg_q.inv <= wb_dat_i[CFG_INV];
			cfg_q.div <= wb_dat_i[CFG_DIV_LSB +: 2];
		end
	end

	// Active clock path. A new source, divider or polarity is taken
	// only at a period boundary, so the switching clock never shows a
	// shortened high or low phase; while stopped it follows at once.
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			cfg_act_q <= '{div: CFG_RESET[CFG_DIV_LSB +: 2],
				inv: CFG_RESET[CFG_INV], src: CFG_RESET[CFG_SRC]};
		end else if (!enable_q || period_start) begin
			cfg_act_q <= cfg_q;
		end
	end

	// On-time wanted for the next period. The own oscillator period
	// gives about 2.4 MHz; the system path is divided by 1, 2, 4 or 8.
	always_comb begin
		want_on = duty_req_i;
		if (startup_q) begin
			want_on = period_new >> 1;
		end else if (duty_req_i > period_new) begin
			want_on = period_new;
		end
	end

	// A requested pulse below the minimum width is dropped whole
	assign do_skip = (min_on != 8'h00) && (want_on != 8'h00) &&
		(want_on < min_on) && !startup_q;

	// Per-period on-time latch. Dropping whole pulses means that at
	// light load the pulse rate falls, not the pulse width.
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i || !enable_q) begin
			on_act_q <= 8'h00;
			skip_q   <= 1'b0;
		end else if (period_start) begin
			if (do_skip) begin
				on_act_q <= 8'h00;
				skip_q   <= 1'b1;
			end else begin
				on_act_q <= want_on;
				skip_q   <= 1'b0;
			end
		end
	end

	// Switch drive. The duty switch closes for the first part of the
	// period, the bypass switch for the rest; never both at once.
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i || !enable_q) begin
			duty_switch_o   <= 1'b0;
			bypass_switch_o <= 1'b0;
		end else begin
			duty_switch_o   <= (phase < on_act_q);
			bypass_switch_o <= ~(phase < on_act_q);
		end
	end

	// Switching clock: high in the first half of each period, flipped
	// when the inverted system clock path is in use.
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i || !enable_q) begin
			sw_clk_o <= 1'b0;
		end else begin
			sw_clk_o <= (phase < (period_act >> 1)) ^
				(cfg_act_q.inv & (cfg_act_q.src == SRC_SYS));
		end
	end

	// Status outputs taken from register and converter state
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			conv_enable_o  <= 1'b0;
			small_switch_o <= CTRL_RESET[CTRL_SWSIZE];
			pulse_skip_o   <= 1'b0;
			adc_sync_o     <= CTRL_RESET[CTRL_SYNC];
		end else begin
			conv_enable_o  <= enable_q;
			small_switch_o <= ctrl_q.small_sw;
			pulse_skip_o   <= skip_q;
			adc_sync_o     <= ctrl_q.sync & enable_q;
		end
	end

	// Read mux. Unmapped offsets read as zero and are still acknowledged.
	always_comb begin
		rd_data = 32'h0000_0000;
		if (wb_adr_i == ADDR_CTRL) begin
			rd_data[CTRL_PW_MIN_LSB +: 2] = ctrl_q.min_pw;
			rd_data[CTRL_SWSIZE]         = ctrl_q.small_sw;
			rd_data[CTRL_SYNC]           = ctrl_q.sync;
		end else if (wb_adr_i == ADDR_CONFIG) begin
			rd_data[CFG_DIV_LSB +: 2] = cfg_q.div;
			rd_data[CFG_INV]          = cfg_q.inv;
			rd_data[CFG_SRC]          = cfg_q.src;
		end else if (wb_adr_i == ADDR_STATUS) begin
			rd_data[STAT_SINGLE]  = single_cell_q;
			rd_data[STAT_ENABLED] = enable_q;
			rd_data[STAT_STARTUP] = startup_q;
			rd_data[STAT_SKIP]    = skip_q;
		end
	end

	// Wishbone answer: one registered ack per access, dropped next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= rd_data;
			end
		end
	end

endmodule

// >>> tb/bcc_asserts.sv
// Port checker for bcc_top, bound to every instance of it.
// Assumes por_i is raised at power-up so the strap copy is known.
`timescale 1ns/1ps
module bcc_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic cell_mode_strap_pin_i,
	input wire logic sleep_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic conv_enable_o,
	input wire logic duty_switch_o,
	input wire logic bypass_switch_o,
	input wire logic adc_sync_o
);
	logic cell_q; // Cell mode copy, taken only in power-on reset
	// Plain resets must not touch this copy, so neither may we
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			cell_q <= cell_mode_strap_pin_i;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || por_i);
	dual_off_a: assert property (!cell_q |-> !conv_enable_o)
		else $error("converter on in dual-cell mode");
	sleep_off_a: assert property (sleep_i |-> ##2 !conv_enable_o)
		else $error("converter on in sleep");
	// A reset still seen at its release edge delays the enable by one
	// cycle, so the awake window counts only edges that saw no reset.
	awake_on_a: assert property
		((cell_q && !sleep_i && !rst_i && !por_i) [*3] |->
		conv_enable_o)
		else $error("converter off while awake");
	switch_excl_a: assert property
		(conv_enable_o && $past(conv_enable_o) |->
		duty_switch_o ^ bypass_switch_o)
		else $error("switch pair not exclusive");
	off_open_a: assert property
		(!conv_enable_o && !$past(conv_enable_o) |->
		!duty_switch_o && !bypass_switch_o)
		else $error("switch closed while disabled");
	sync_gate_a: assert property
		(adc_sync_o |-> conv_enable_o || $past(conv_enable_o))
		else $error("adc sync without converter");
	ack_next_a: assert property
		(wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	ack_cause_a: assert property
		($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("bus ack without request");
endmodule
bind bcc_top bcc_asserts chk_u (.*);

// >>> tb/bcc_loop_model.sv
// Far side model: power stage, output capacitor and switch monitor.
// Assumes the clock of bcc_top; rst_i is the power-on reset.
`timescale 1ns/1ps
module bcc_loop_model #(parameter int CHARGE = 300) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic conv_enable_i,
	input  wire logic duty_switch_i,
	input  wire logic sw_clk_i,
	output logic      reg_ok_o,
	output logic [7:0] per_o,
	output logic [7:0] on_o,
	output logic      clk_at_on_o
);
	logic [8:0] chg_q; // Charge on the output capacitor
	logic [7:0] pc_q;  // Cycles since last switching clock rise
	logic [7:0] oc_q;  // Cycles the duty switch has been closed
	logic       sw_q;  // Last switching clock level
	logic       dq_q;  // Last duty switch level
	// Regulation is reached once switching has charged the output
	assign reg_ok_o = (chg_q >= 9'(CHARGE));
	// Charge only leaks away at power-on, not on a plain reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chg_q <= '0;
		end else if (conv_enable_i && !reg_ok_o) begin
			chg_q <= chg_q + 9'h001;
		end
	end
	// Measure period, on-time and clock phase at switch closure
	always_ff @(posedge clk_i) begin
		sw_q <= sw_clk_i;
		dq_q <= duty_switch_i;
		pc_q <= (sw_clk_i && !sw_q) ? 8'h01 : pc_q + 8'h01;
		oc_q <= duty_switch_i ? oc_q + 8'h01 : 8'h00;
		if (sw_clk_i && !sw_q) begin
			per_o <= pc_q;
		end
		if (!duty_switch_i && dq_q) begin
			on_o <= oc_q;
		end
		if (duty_switch_i && !dq_q) begin
			clk_at_on_o <= sw_clk_i;
		end
	end
endmodule

// >>> tb/bcc_top_tb.sv
// Testbench of bcc_top: Wishbone tasks, scenarios and verdict.
// Assumes bcc_asserts is bound and the loop model is the far side.
`timescale 1ns/1ps
module bcc_top_tb
	import bcc_pkg::*;
;
	logic        clk_i = 0, rst_i = 0, por_i = 1;
	logic        cell_mode_strap_pin_i = 1, sleep_i = 0;
	logic [7:0]  duty_req_i = 8'h03, wb_adr_i = 8'h00;
	logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic        wb_ack_o, conv_enable_o, duty_switch_o;
	logic        bypass_switch_o, small_switch_o, sw_clk_o;
	logic        pulse_skip_o, adc_sync_o, reg_ok_i, con;
	logic [7:0]  per, on;
	int          miscompares = 0, n_checks = 0, n;
	logic [7:0]  mw [4] = '{8'h00, PW_MIN_1_CYC, PW_MIN_2_CYC,
		PW_MIN_3_CYC};
	bcc_top dut_u (.*);
	bcc_loop_model lm_u (.clk_i(clk_i), .rst_i(por_i),
		.conv_enable_i(conv_enable_o), .duty_switch_i(duty_switch_o),
		.sw_clk_i(sw_clk_o), .reg_ok_o(reg_ok_i), .per_o(per),
		.on_o(on), .clk_at_on_o(con));
	// 20 MHz clock at one fixed rate: the source is never trimmed upward
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	// One classic cycle; holds until ack, then idles one cycle
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int t;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 20);
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		if (t >= 20) begin
			miscompares++;
			stop_test();
		end
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		por_i <= 0;
		@(posedge clk_i);
		rd(ADDR_CTRL, 32'(CTRL_RESET));
		chk(small_switch_o, 1);
		rd(ADDR_CONFIG, 32'(CFG_RESET));
		rd(ADDR_STATUS, 32'h07);
		rd(8'h0C, 32'h0);
		cyc(40);
		chk(per, OSC_PERIOD_CYC);
		chk(on, OSC_PERIOD_CYC >> 1);
		$display("test startup done");
		n = 0;
		while (reg_ok_i !== 1'b1 && n < 1000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 1000) begin
			miscompares++;
			stop_test();
		end
		cyc(30);
		rd(ADDR_STATUS, 32'h03);
		chk(on, 3);
		duty_req_i <= 8'h01;
		for (int d = 0; d < 4; d++) begin
			wr(ADDR_CONFIG, 32'(d << CFG_DIV_LSB) | 32'h1);
			cyc(50);
			chk(per, SYS_BASE_CYC << d);
			chk(con, 1);
		end
		wr(ADDR_CONFIG, 32'h29);
		cyc(30);
		chk(con, 0);
		chk(per, SYS_BASE_CYC << 1);
		wr(ADDR_CONFIG, 32'h08);
		cyc(30);
		chk(con, 1);
		chk(per, OSC_PERIOD_CYC);
		$display("test clocking done");
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_CTRL, 32'(m << CTRL_PW_MIN_LSB));
			cyc(30);
			chk(pulse_skip_o, mw[m] > 1);
			chk(small_switch_o, 0);
		end
		n = 0;
		repeat (16) begin
			@(posedge clk_i);
			n += duty_switch_o;
		end
		chk(n, 0);
		rd(ADDR_STATUS, 32'h0B);
		duty_req_i <= mw[3];
		cyc(30);
		chk(pulse_skip_o, 0);
		chk(on, mw[3]);
		$display("test skipping done");
		wr(ADDR_CTRL, 32'h08);
		cyc(2);
		chk(adc_sync_o, 1);
		sleep_i <= 1;
		cyc(4);
		chk(conv_enable_o, 0);
		chk(adc_sync_o, 0);
		sleep_i <= 0;
		cyc(4);
		chk(conv_enable_o, 1);
		$display("test sleep done");
		cell_mode_strap_pin_i <= 0;
		rst_i <= 1;
		cyc(2);
		rst_i <= 0;
		cyc(4);
		chk(conv_enable_o, 1);
		rd(ADDR_STATUS, 32'h03);
		por_i <= 1;
		cyc(2);
		por_i <= 0;
		cyc(4);
		chk(conv_enable_o, 0);
		cell_mode_strap_pin_i <= 1;
		cyc(4);
		chk(conv_enable_o, 0);
		$display("test cell mode done");
		stop_test();
	end
endmodule
